// ### hw/rpf_top.sv
// Registered sum-of-products array with test preload and security fuse.
// Assumes a programmer drives pins; pins are synchronised to i_ref_clk.
`timescale 1ns/1ps
`default_nettype none
module rpf_top #(
    parameter int NREG = rpf_pkg::NUM_REGS
) (
    input  wire logic                            i_ref_clk,
    input  wire logic                            i_rst_n,
    // Array inputs and registered pins
    input  wire logic [11:0]                     i_ded_in,
    input  wire logic [NREG-1:0]                 i_reg_pin,
    input  wire logic                            i_oe_n,
    input  wire logic                            i_elevated_preload_level,
    // Programming port
    input  wire logic                            i_prog_req,
    input  wire logic                            i_verify_req,
    input  wire logic                            i_fuse_prog,
    input  wire logic [rpf_pkg::PLINE_W-1:0]     i_pline,
    input  wire logic [rpf_pkg::ILINE_W-1:0]     i_iline,
    input  wire logic                            i_map_bit,
    // Outputs
    output logic      [NREG-1:0]                 o_reg_pin_n,
    output logic      [NREG-1:0]                 o_reg_pin_oe,
    output logic                                 o_verify_data,
    output logic                                 o_verify_valid,
    output logic                                 o_refused,
    output logic                                 o_secured
);
    localparam int NCELL = rpf_pkg::NUM_CELLS;

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [NREG-1:0] pin_s1, pin_s2;
    logic [11:0]     ded_s1, ded_s2;
    logic [5:0]      ctl_s1, ctl_s2;
    wire  logic [5:0] ctl_raw;
    assign ctl_raw = {i_oe_n, i_elevated_preload_level, i_prog_req,
                      i_verify_req, i_fuse_prog, i_map_bit};

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
            ded_s1 <= '0;
            ded_s2 <= '0;
            ctl_s1 <= 6'h20;
            ctl_s2 <= 6'h20;
        end else begin
            pin_s1 <= i_reg_pin;
            pin_s2 <= pin_s1;
            ded_s1 <= i_ded_in;
            ded_s2 <= ded_s1;
            ctl_s1 <= ctl_raw;
            ctl_s2 <= ctl_s1;
        end
    end

    wire logic oe_n, preload, prog_lvl, ver_lvl, fuse_lvl, map_bit;
    assign {oe_n, preload, prog_lvl, ver_lvl, fuse_lvl, map_bit} = ctl_s2;

    // Line numbers take the same two stages, so they meet their request
    logic [rpf_pkg::PLINE_W-1:0] pl_s1, pl_s2;
    logic [rpf_pkg::ILINE_W-1:0] il_s1, il_s2;

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pl_s1 <= '0;
            pl_s2 <= '0;
            il_s1 <= '0;
            il_s2 <= '0;
        end else begin
            pl_s1 <= i_pline;
            pl_s2 <= pl_s1;
            il_s1 <= i_iline;
            il_s2 <= il_s1;
        end
    end

    // Requests act on rising edge only
    logic prog_d, ver_d, fuse_d;
    wire  logic prog_go, ver_go, fuse_go;
    assign prog_go = prog_lvl & ~prog_d;
    assign ver_go  = ver_lvl & ~ver_d;
    assign fuse_go = fuse_lvl & ~fuse_d;

    // ****************************************************************
    // Fuse array and security fuse
    // ****************************************************************
    logic [NCELL-1:0] cell_map;
    logic             secured;
    wire  logic [rpf_pkg::CELL_ADDR_W-1:0] addr;
    wire  logic       addr_ok;

    rpf_cell_addr #(
        .STRIDE (rpf_pkg::LINE_STRIDE)
    ) u_addr (
        .i_pline (pl_s2),
        .i_iline (il_s2),
        .o_addr  (addr)
    );

    // An input line past the row would alias the next row's cells
    assign addr_ok = (addr < rpf_pkg::CELL_ADDR_W'(NCELL)) &&
                     (il_s2 < rpf_pkg::ILINE_W'(rpf_pkg::NUM_INPUT_LINES));

    wire logic prog_ok, ver_ok, any_req;
    assign any_req = prog_go | ver_go | fuse_go;
    assign prog_ok = prog_go & ~secured & addr_ok;
    assign ver_ok  = ver_go & ~secured & addr_ok;

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            // Unprogrammed: every cell open, as map value one
            cell_map <= {NCELL{rpf_pkg::MAP_OPEN}};
            secured  <= rpf_pkg::FUSE_RESET_VAL;
            prog_d   <= 1'b0;
            ver_d    <= 1'b0;
            fuse_d   <= 1'b0;
        end else begin
            prog_d <= prog_lvl;
            ver_d  <= ver_lvl;
            fuse_d <= fuse_lvl;
            if (prog_ok) begin
                cell_map[addr] <= map_bit;
            end
            if (fuse_go) begin
                secured <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Sum-of-products array
    // ****************************************************************
    logic [NREG-1:0] regs;
    wire  logic [rpf_pkg::NUM_INPUT_LINES-1:0] lines;
    wire  logic [19:0] true_in;
    wire  logic [rpf_pkg::NUM_PRODUCT_LINES-1:0] pterm;
    wire  logic [NREG-1:0] sop;

    // Feedback from registers continues while outputs are disabled
    assign true_in = {regs, ded_s2};
    genvar gi, gp;
    generate
        for (gi = 0; gi < 20; gi++) begin : g_line
            assign lines[2*gi]   = true_in[gi];
            assign lines[2*gi+1] = ~true_in[gi];
        end
        for (gp = 0; gp < rpf_pkg::NUM_PRODUCT_LINES; gp++) begin : g_pt
            // Zero in the map is a connection
            assign pterm[gp] = &(lines | cell_map[gp*rpf_pkg::LINE_STRIDE
                               +: rpf_pkg::NUM_INPUT_LINES]);
        end
        for (gi = 0; gi < NREG; gi++) begin : g_or
            assign sop[gi] = |pterm[gi*rpf_pkg::TERMS_PER_OUT
                                    +: rpf_pkg::TERMS_PER_OUT];
        end
    endgenerate

    // ****************************************************************
    // Output registers with preload path
    // ****************************************************************
    // Preload ignores the security fuse on purpose
    wire logic [NREG-1:0] next_regs;
    assign next_regs = preload ? pin_s2 : sop;

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            regs <= {NREG{rpf_pkg::REG_RESET_VAL}};
        end else begin
            regs <= next_regs;
        end
    end

    // ****************************************************************
    // Output decode
    // ****************************************************************
    wire logic [NREG-1:0] next_pin_n;
    wire logic [NREG-1:0] next_pin_oe;
    wire logic            next_verify_data;
    wire logic            next_refused;

    assign next_pin_n       = ~next_regs;
    // Pins float in preload so tester data never fights the drivers
    assign next_pin_oe      = {NREG{~oe_n & ~preload}};
    assign next_verify_data = ver_ok ? cell_map[addr] : 1'b0;
    // A fuse request is never flagged, even when already secured
    assign next_refused     = any_req & secured & ~fuse_go;

    // Pins driven only outside preload and while enable is low
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_reg_pin_n    <= '1;
            o_reg_pin_oe   <= '0;
            o_verify_data  <= 1'b0;
            o_verify_valid <= 1'b0;
            o_refused      <= 1'b0;
            o_secured      <= 1'b0;
        end else begin
            o_reg_pin_n    <= next_pin_n;
            o_reg_pin_oe   <= next_pin_oe;
            o_verify_data  <= next_verify_data;
            o_verify_valid <= ver_ok;
            o_refused      <= next_refused;
            o_secured      <= secured;
        end
    end

endmodule : rpf_top
`default_nettype wire

// ### hw/rpf_pkg.sv
// Package for the register preload and fuse-map block.
// Assumes one 125 MHz reference clock and an active-low async reset.
package rpf_pkg;

    // ****************************************************************
    // Array geometry
    // ****************************************************************
    localparam int NUM_REGS          = 8;
    localparam int NUM_INPUT_LINES   = 40;
    localparam int NUM_PRODUCT_LINES = 64;
    localparam int TERMS_PER_OUT     = 8;
    localparam int NUM_CELLS         = NUM_PRODUCT_LINES * NUM_INPUT_LINES;
    localparam int CELL_ADDR_W       = 12;
    localparam int LINE_STRIDE       = 40;
    localparam int PLINE_W           = 6;
    localparam int ILINE_W           = 6;

    // ****************************************************************
    // Fuse-map encoding and reset values
    // ****************************************************************
    localparam logic MAP_CONNECTED   = 1'b0;
    localparam logic MAP_OPEN        = 1'b1;
    localparam logic REG_RESET_VAL   = 1'b1;
    localparam logic FUSE_RESET_VAL  = 1'b0;

endpackage : rpf_pkg

// ### hw/rpf_cell_addr.sv
// Cell address calculator: product line times stride plus input line.
// Assumes line numbers are in range; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module rpf_cell_addr #(
    parameter int STRIDE = rpf_pkg::LINE_STRIDE
) (
    input  wire logic [rpf_pkg::PLINE_W-1:0]     i_pline,
    input  wire logic [rpf_pkg::ILINE_W-1:0]     i_iline,
    output logic      [rpf_pkg::CELL_ADDR_W-1:0] o_addr
);
    wire logic [rpf_pkg::CELL_ADDR_W-1:0] first_cell;

    assign first_cell = rpf_pkg::CELL_ADDR_W'(i_pline * STRIDE);
    assign o_addr     = first_cell + rpf_pkg::CELL_ADDR_W'(i_iline);
endmodule : rpf_cell_addr
`default_nettype wire

// ### verif/rpf_top_chk.sv
// Port checker for rpf_top.
// Assumes bind into rpf_top; i_rst_n low clears all state.
`timescale 1ns/1ps
`default_nettype none
module rpf_top_chk #(
    parameter int NREG = 8
) (
    input wire logic            i_ref_clk,
    input wire logic            i_rst_n,
    input wire logic [NREG-1:0] i_reg_pin,
    input wire logic            i_oe_n,
    input wire logic            i_elevated_preload_level,
    input wire logic            i_verify_req,
    input wire logic [NREG-1:0] o_reg_pin_n,
    input wire logic [NREG-1:0] o_reg_pin_oe,
    input wire logic            o_verify_valid,
    input wire logic            o_refused,
    input wire logic            o_secured
);
    // ****
    // Properties
    // ****
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_n);
    sequence s_pre;
        i_elevated_preload_level && $stable(i_reg_pin);
    endsequence
    sequence s_ask;
        $rose(i_verify_req);
    endsequence
    AST_PRE_LOAD: assert property (
        s_pre [*7] |-> o_reg_pin_n == ~i_reg_pin)
        else $error("preload data not loaded");
    AST_PRE_HIZ: assert property (
        i_elevated_preload_level [*4] |-> o_reg_pin_oe == '0)
        else $error("pins driven in preload");
    AST_OE_ON: assert property (
        (!i_oe_n && !i_elevated_preload_level) [*5] |-> &o_reg_pin_oe)
        else $error("outputs not enabled");
    AST_OE_OFF: assert property (
        i_oe_n [*5] |-> o_reg_pin_oe == '0)
        else $error("outputs not disabled");
    AST_REFUSE: assert property (
        s_ask ##0 o_secured |-> ##[2:6] o_refused)
        else $error("secured verify not refused");
    AST_SILENT: assert property (
        o_secured && $past(o_secured, 8) |-> !o_verify_valid)
        else $error("verify answered while secured");
    AST_ANSWER: assert property (
        s_ask ##0 !o_secured |-> ##[2:6] o_verify_valid)
        else $error("verify not answered");
    AST_STICKY: assert property (
        o_secured |=> o_secured)
        else $error("security fuse cleared");
    AST_PULSE: assert property (
        o_refused |=> !o_refused)
        else $error("refused longer than one cycle");
endmodule : rpf_top_chk
bind rpf_top rpf_top_chk #(.NREG(NREG)) i_rpf_top_chk (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_reg_pin(i_reg_pin),
    .i_oe_n(i_oe_n), .i_elevated_preload_level(i_elevated_preload_level),
    .i_verify_req(i_verify_req), .o_reg_pin_n(o_reg_pin_n),
    .o_reg_pin_oe(o_reg_pin_oe), .o_verify_valid(o_verify_valid),
    .o_refused(o_refused), .o_secured(o_secured)
);
`default_nettype wire

// ### verif/rpf_prog_model.sv
// Tester model: preload pins and output enable of rpf_top.
// Assumes the bench calls its tasks just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module rpf_prog_model #(
    parameter int NREG = 8
) (
    input  wire logic            i_ref_clk,
    input  wire logic [NREG-1:0] i_pin_n,
    input  wire logic [NREG-1:0] i_pin_oe,
    output logic      [NREG-1:0] o_pin,
    output logic                 o_oe_n,
    output logic                 o_preload
);
    logic            drv = 1'h0;
    logic [NREG-1:0] dat = '0;
    // Released pins show inverted data, so stale values cannot pass
    assign o_pin = drv ? dat : (i_pin_oe & i_pin_n) | (~i_pin_oe & ~dat);
    initial begin
        o_oe_n = 1'h0;
        o_preload = 1'h0;
    end
    task automatic begin_preload(input logic [NREG-1:0] d, input int gap);
        @(posedge i_ref_clk) #1 o_oe_n = 1'h1;
        repeat (gap) @(posedge i_ref_clk);
        #1 dat = d;
        drv = 1'h1;
        repeat (gap) @(posedge i_ref_clk);
        #1 o_preload = 1'h1;
    endtask : begin_preload
    task automatic end_preload;
        @(posedge i_ref_clk) #1 o_preload = 1'h0;
        drv = 1'h0;
        repeat (3) @(posedge i_ref_clk);
        #1 o_oe_n = 1'h0;
        repeat (6) @(posedge i_ref_clk);
        #1;
    endtask : end_preload
endmodule : rpf_prog_model
`default_nettype wire

// ### verif/register_preload_fuse_map_test.sv
// Self-checking bench for rpf_top with a tester model.
// Assumes rpf_top_chk is bound in; 125 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module register_preload_fuse_map_test;
    logic        clk, rst_n, oe_n, pre, preq, vreq, fprog, mbit;
    logic        vdat, vval, refd, sec;
    logic [11:0] ded;
    logic [7:0]  pin, pin_n, oe;
    logic [5:0]  pl, il;
    int          failures = 0;
    int          cmp_count = 0;
    int          cycles = 0;
    int          pa[28];
    int          ia[28];
    int          bp[4] = '{0, 63, 1, 0};
    int          bi[4] = '{0, 39, 0, 39};
    bit          map[2560] = '{default: 1'b1};
    bit          secm = 1'b0;
    rpf_top i_rpf_top (
        .i_ref_clk(clk), .i_rst_n(rst_n), .i_ded_in(ded), .i_reg_pin(pin),
        .i_oe_n(oe_n), .i_elevated_preload_level(pre), .i_prog_req(preq),
        .i_verify_req(vreq), .i_fuse_prog(fprog), .i_pline(pl),
        .i_iline(il), .i_map_bit(mbit), .o_reg_pin_n(pin_n),
        .o_reg_pin_oe(oe), .o_verify_data(vdat), .o_verify_valid(vval),
        .o_refused(refd), .o_secured(sec));
    rpf_prog_model i_rpf_prog_model (.i_ref_clk(clk), .i_pin_n(pin_n),
        .i_pin_oe(oe), .o_pin(pin), .o_oe_n(oe_n), .o_preload(pre));
    // ****
    // Tasks
    // ****
    task automatic chk(input string nm, input logic [7:0] e, logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Next register state from the bench's own copy of the cell map
    function automatic logic [7:0] sop_model(input logic [7:0] r,
                                             input logic [11:0] d);
        logic [19:0] v;
        logic [7:0]  s;
        bit          t;
        v = {r, d};
        s = 8'h00;
        for (int p = 0; p < 64; p++) begin
            t = 1'h1;
            for (int i = 0; i < 40; i++) begin
                if (map[p * 40 + i] == 1'h0 && v[i / 2] == i[0]) t = 1'h0;
            end
            if (t) s[p / 8] = 1'h1;
        end
        return s;
    endfunction : sop_model
    task automatic give_verdict;
        if (failures == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : give_verdict
    task automatic req(input int k, input int p, input int i, input bit b);
        logic gv, gr, gd;
        int a;
        {gv, gr, gd} = 3'h0;
        {pl, il, mbit} = {6'(p), 6'(i), b};
        {preq, vreq, fprog} = {k == 0, k == 1, k == 2};
        for (int n = 0; n < 8; n++) begin
            @(posedge clk) #1;
            if (n == 3) {preq, vreq, fprog} = 3'h0;
            if (vval !== 1'h0) gv = 1'h1;
            if (vval !== 1'h0) gd = vdat;
            if (refd !== 1'h0) gr = 1'h1;
        end
        a = p * 40 + i;
        chk("answered", 8'(k == 1 && !secm), 8'(gv));
        chk("refused", 8'(k != 2 && secm), 8'(gr));
        if (k == 1 && !secm) chk("cell", 8'(map[a]), 8'(gd));
        if (k == 0 && !secm) map[a] = b;
        secm = secm | (k == 2);
        chk("secured", 8'(secm), 8'(sec));
    endtask : req
    task automatic pre_chk;
        logic [7:0] d;
        for (int n = 0; n < 3; n++) begin
            d = 8'($urandom);
            ded = 12'($urandom);
            i_rpf_prog_model.begin_preload(d, 1 + $urandom % 4);
            repeat (8) @(posedge clk);
            #1 chk("preload out", ~d, pin_n);
            chk("oe preload", 8'h00, oe);
            i_rpf_prog_model.end_preload();
            chk("oe after", 8'hFF, oe);
            d = ~pin_n;
            @(posedge clk) #1;
            chk("array step", ~sop_model(d, ded), pin_n);
        end
    endtask : pre_chk
    initial begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            give_verdict();
        end
    end
    initial begin
        void'($urandom(16593));
        {rst_n, ded, preq, vreq, fprog, pl, il, mbit} = '0;
        repeat (16) @(posedge clk);
        #1 rst_n = 1'h1;
        repeat (3) @(posedge clk);
        #1 pre_chk();
        for (int n = 0; n < 28; n++) begin
            pa[n] = n < 4 ? bp[n] : $urandom % 64;
            ia[n] = n < 4 ? bi[n] : $urandom % 40;
            req(0, pa[n], ia[n], n < 4 ? 1'(n) : 1'($urandom));
        end
        for (int n = 0; n < 34; n++) begin
            if (n == 30) req(2, 0, 0, 1'h0);
            req(n < 30 ? 1 : n % 2, pa[n % 28], ia[n % 28], 1'h1);
        end
        pre_chk();
        give_verdict();
    end
endmodule : register_preload_fuse_map_test
`default_nettype wire
